// ===== dv/sfsc_far_model.sv
// Purpose: far-side model: steering device, position sensor, closed-loop source
// Assumes: bench sets the wanted values by non-blocking assignment on clk
// Notes:   an unmapped position sensor inverts its last word every cycle, giving toggling junk
`timescale 1ns/10ps
`default_nettype none
module sfsc_far_model (
    input  wire logic               clk,
    input  wire logic signed [10:0] steer_set,
    input  wire logic signed [10:0] pos_set,
    input  wire logic               mapped_set,
    input  wire logic signed [10:0] cmd_set,
    output logic signed [10:0]      steering_input,
    output logic signed [10:0]      actuator_position,
    output logic                    position_mapped,
    output logic signed [10:0]      closed_loop_flow_cmd
);
    always_ff @(posedge clk) begin
        steering_input       <= steer_set;
        closed_loop_flow_cmd <= cmd_set;
        position_mapped      <= mapped_set;
    end
    // junk when unmapped
    // the device must ignore this word, so it is made to change every cycle
    always_ff @(posedge clk) begin
        actuator_position <= mapped_set ? pos_set : ~actuator_position;
    end
endmodule : sfsc_far_model
`default_nettype wire

// ===== dv/sfsc_setpoint_checker.sv
// Purpose: port-level checks of the steering set-point block
// Assumes: threshold register never exceeds 100, flows within +-1000
// Notes:   only ports are visible, so register-dependent limits use their maxima
`timescale 1ns/10ps
`default_nettype none
module sfsc_setpoint_checker (
    input wire logic               clk,
    input wire logic               rst_b,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [11:0]        paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic signed [10:0] steering_input,
    input wire logic signed [10:0] actuator_position,
    input wire logic               position_mapped,
    input wire logic signed [10:0] closed_loop_flow_cmd,
    input wire logic signed [10:0] port_flow_request,
    input wire logic               spool_neutral,
    input wire logic               bridge_enable,
    input wire logic               open_loop_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [10:0] cmd_mag;
    assign cmd_mag = closed_loop_flow_cmd[10] ? 11'(-closed_loop_flow_cmd) : closed_loop_flow_cmd;

    AST_BRIDGE_ON: assert property (port_flow_request != 11'sh000 |-> bridge_enable)
        else $error("bridge disabled while flow requested");
    AST_BRIDGE_OFF_CAUSE: assert property ($fell(bridge_enable) |->
        port_flow_request == 11'sh000 && $past(port_flow_request) == 11'sh000)
        else $error("bridge dropped without zero flow");
    AST_NEUTRAL_DROP: assert property (cmd_mag > 11'h064 |=> !spool_neutral)
        else $error("spool stays neutral above threshold");
    AST_NEUTRAL_SETTLED: assert property ($rose(spool_neutral) |->
        $past(cmd_mag) <= 11'h064)
        else $error("spool neutral entered with large command");
    AST_CLOSED_PASS: assert property ((!open_loop_active ##1 !open_loop_active) |->
        port_flow_request == $past(closed_loop_flow_cmd))
        else $error("closed-loop command not passed through");
    AST_DEADBAND_ZERO: assert property ((open_loop_active && steering_input == 11'sh000
        ##1 open_loop_active) |-> port_flow_request == 11'sh000)
        else $error("released handle requests flow");
    AST_CLAMP: assert property ((port_flow_request <= 11'sd1000)
        && (port_flow_request >= -11'sd1000))
        else $error("flow beyond full scale");
    AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    AST_RESET_VALUES: assert property (disable iff (1'b0) !rst_b |=> bridge_enable &&
        !spool_neutral && open_loop_active && port_flow_request == 11'sh000)
        else $error("wrong outputs after reset");

    cover property ($rose(spool_neutral));
    cover property ($fell(bridge_enable));
    cover property (pslverr);
    cover property (!open_loop_active && port_flow_request != 11'sh000);
endmodule : sfsc_setpoint_checker
bind sfsc_setpoint sfsc_setpoint_checker u_chk (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .steering_input(steering_input),
    .actuator_position(actuator_position), .position_mapped(position_mapped),
    .closed_loop_flow_cmd(closed_loop_flow_cmd), .port_flow_request(port_flow_request),
    .spool_neutral(spool_neutral), .bridge_enable(bridge_enable),
    .open_loop_active(open_loop_active));
`default_nettype wire

// ===== dv/testbench.sv
// Purpose: register, set-point, neutral and bridge tests of the set-point block
// Assumes: MS_CYCLES shortened to 10, so one ms is ten clocks
// Notes:   expected flows come from a model of the transfer function below
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic                clk = 1'b0;
    logic                rst_b, psel, penable, pwrite, pready, pslverr, rerr;
    logic                spool_neutral, bridge_enable, open_loop_active, position_mapped, mapped_set;
    logic [11:0]         paddr;
    logic [31:0]         pwdata, prdata, rdat;
    logic signed [10:0]  steering_input, actuator_position, closed_loop_flow_cmd;
    logic signed [10:0]  steer_set, pos_set, cmd_set, port_flow_request;
    int                  n_fail, cmp_count, i, k;
    // refused writes: address, value (status, ranges, program, misaligned)
    int bad [10][2] = '{'{16,0}, '{8,101}, '{0,5}, '{4,0}, '{12,30001}, '{72,11},
                        '{84,19}, '{68,251}, '{80,3}, '{2,0}};
    // steer, pos, mapped, dead band, linearity, max flow, source, base, end
    int oc [10][9] = '{'{30,0,1,50,0,1000,1,105,90}, '{1000,0,1,50,0,1000,1,105,90},
        '{-600,0,1,50,10,1000,1,105,90}, '{600,0,1,50,-10,1000,1,105,90},
        '{900,0,1,0,0,400,1,120,90}, '{700,500,1,50,0,1000,2,105,90},
        '{700,-500,1,50,0,1000,2,105,90}, '{700,800,0,50,0,1000,2,200,20},
        '{250,0,1,250,0,1000,1,105,90}, '{-1000,1000,1,250,0,1000,2,20,1200}};

    always #5 clk = ~clk;

    sfsc_far_model u_far (.clk(clk), .steer_set(steer_set), .pos_set(pos_set),
        .mapped_set(mapped_set), .cmd_set(cmd_set), .steering_input(steering_input),
        .actuator_position(actuator_position), .position_mapped(position_mapped),
        .closed_loop_flow_cmd(closed_loop_flow_cmd));
    sfsc_setpoint #(.MS_CYCLES(10)) uut (.clk(clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .steering_input(steering_input),
        .actuator_position(actuator_position), .position_mapped(position_mapped),
        .closed_loop_flow_cmd(closed_loop_flow_cmd), .port_flow_request(port_flow_request),
        .spool_neutral(spool_neutral), .bridge_enable(bridge_enable),
        .open_loop_active(open_loop_active));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t ns: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk(32'(n < 20), 32'h1);
    endtask : apb

    task automatic wr(input logic [11:0] a, input int d, input logic e);
        apb(1'b1, a, d);
        chk(rerr, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rerr, 1'b0);
        chk(rdat, exp);
    endtask : rd

    function automatic logic [11:0] fa(input int p, input int f);
        return sfsc_pkg::OFF_PROG_BASE + 12'(p * 32 + f * 4);
    endfunction : fa

    function automatic int exp_flow(input int r [9]);
        int a, e, s, p, g, f;
        a = (r[0] < 0) ? -r[0] : r[0];
        e = (a - r[3] < 0) ? 0 : ((a - r[3] > 1000) ? 1000 : a - r[3]);
        s = e - r[4] * e * (1000 - e) / 20000;
        p = (r[2] == 0) ? 0 : ((r[1] < 0) ? -r[1] : r[1]);
        g = (r[6] == 2) ? r[7] + (r[8] - r[7]) * p / 1000 : r[7];
        f = (s * g / 100 > r[5]) ? r[5] : s * g / 100;
        return (r[0] < 0) ? -f : f;
    endfunction : exp_flow

    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    initial begin
        #100_000;
        n_fail++;
        conclude();
    end

    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
        {steer_set, pos_set, cmd_set, mapped_set} = {33'h0, 1'b1};
        n_fail = 0;
        cmp_count = 0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rd(sfsc_pkg::OFF_ACTIVE_PROG, 0);
        rd(sfsc_pkg::OFF_NEUTRAL_DELAY, 3000);
        rd(sfsc_pkg::OFF_FLOW_THRESH, 50);
        rd(sfsc_pkg::OFF_BRIDGE_DELAY, 30000);
        rd(sfsc_pkg::OFF_STATUS, 32'h6);
        for (i = 0; i < 10; i += 9) begin
            rd(fa(i, 0), 0);
            rd(fa(i, 1), 50);
            rd(fa(i, 2), 0);
            rd(fa(i, 3), 1000);
            rd(fa(i, 4), 1);
            rd(fa(i, 5), 105);
            rd(fa(i, 6), 90);
        end
        $display("test reset_values done");
        for (i = 0; i < 10; i++) wr(12'(bad[i][0]), bad[i][1], 1'b1);
        apb(1'b0, 12'h3fc, 32'h0);
        chk(rerr, 1'b1);
        rd(sfsc_pkg::OFF_FLOW_THRESH, 50);
        wr(fa(0, 2), -10, 1'b0);
        rd(fa(0, 2), 32'hfffffff6);
        wr(fa(9, 1), 250, 1'b0);
        rd(fa(9, 1), 250);
        rd(fa(0, 1), 50);
        $display("test refusals done");
        // row 1 has the base gradient set as qm*100/(1000-db)
        for (i = 0; i < 10; i++) begin
            for (k = 0; k < 6; k++) wr(fa(0, k + 1), oc[i][k + 3], 1'b0);
            steer_set  <= 11'(oc[i][0]);
            pos_set    <= 11'(oc[i][1]);
            mapped_set <= oc[i][2][0];
            repeat (4) @(posedge clk);
            chk(port_flow_request, exp_flow(oc[i]));
        end
        $display("test transfer done");
        wr(fa(3, 3), 200, 1'b0);
        wr(fa(4, 0), 1, 1'b0);
        steer_set <= 11'sd1000;
        wr(sfsc_pkg::OFF_ACTIVE_PROG, 3, 1'b0);
        repeat (3) @(posedge clk);
        chk(port_flow_request, 200);
        wr(sfsc_pkg::OFF_ACTIVE_PROG, 4, 1'b0);
        cmd_set <= -11'sd333;
        repeat (3) @(posedge clk);
        chk(open_loop_active, 1'b0);
        chk(port_flow_request, -333);
        $display("test programs done");
        wr(sfsc_pkg::OFF_NEUTRAL_DELAY, 5, 1'b0);
        wr(sfsc_pkg::OFF_FLOW_THRESH, 20, 1'b0);
        cmd_set <= -11'sd20;
        repeat (30) @(posedge clk);
        chk(spool_neutral, 1'b0);
        for (k = 0; k < 40 && spool_neutral !== 1'b1; k++) @(posedge clk);
        chk(spool_neutral, 1'b1);
        rd(sfsc_pkg::OFF_STATUS, 32'hffec0003);
        cmd_set <= 11'sd21;
        repeat (3) @(posedge clk);
        chk(spool_neutral, 1'b0);
        $display("test neutral done");
        wr(sfsc_pkg::OFF_ACTIVE_PROG, 0, 1'b0);
        steer_set <= 11'sd0;
        repeat (150) @(posedge clk);
        chk(bridge_enable, 1'b1);
        steer_set <= -11'sd1000;
        wr(sfsc_pkg::OFF_BRIDGE_DELAY, 3, 1'b0);
        steer_set <= 11'sd0;
        repeat (12) @(posedge clk);
        chk(bridge_enable, 1'b1);
        for (k = 0; k < 40 && bridge_enable !== 1'b0; k++) @(posedge clk);
        chk(bridge_enable, 1'b0);
        steer_set <= -11'sd1000;
        for (k = 0; k < 5 && port_flow_request === 11'sh000; k++) @(posedge clk);
        chk(bridge_enable, 1'b1);
        $display("test bridge done");
        conclude();
    end
endmodule : testbench
`default_nettype wire

// ===== verilog/sfsc_pkg.sv
// Purpose: constants and types of the steering flow set-point control
// Assumes: 100 MHz clock, flows in 0.1 % of max port flow (1000 = 100 %)
// Notes:   byte offsets of the APB register map
`default_nettype none
package sfsc_pkg;
    localparam int CLK_HZ    = 100_000_000;
    localparam int TICK_MS   = 1;
    localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;

    localparam int NUM_PROG = 10;
    localparam int NUM_SEL  = 5;

    localparam logic [11:0] OFF_ACTIVE_PROG   = 12'h000;
    localparam logic [11:0] OFF_NEUTRAL_DELAY = 12'h004;
    localparam logic [11:0] OFF_FLOW_THRESH   = 12'h008;
    localparam logic [11:0] OFF_BRIDGE_DELAY  = 12'h00c;
    localparam logic [11:0] OFF_STATUS        = 12'h010;
    localparam logic [11:0] OFF_PROG_BASE     = 12'h040;
    localparam int          PROG_STRIDE_SH    = 5;

    localparam logic [2:0] FLD_CTRL_PRINCIPLE = 3'h0;
    localparam logic [2:0] FLD_DEAD_BAND      = 3'h1;
    localparam logic [2:0] FLD_LINEARITY      = 3'h2;
    localparam logic [2:0] FLD_MAX_FLOW       = 3'h3;
    localparam logic [2:0] FLD_SENS_SOURCE    = 3'h4;
    localparam logic [2:0] FLD_BASE_GRAD      = 3'h5;
    localparam logic [2:0] FLD_END_GRAD       = 3'h6;

    localparam logic [14:0]       RST_NEUTRAL_DELAY = 15'h0bb8;
    localparam logic [6:0]        RST_FLOW_THRESH   = 7'h32;
    localparam logic [14:0]       RST_BRIDGE_DELAY  = 15'h7530;
    localparam logic [1:0]        RST_CTRL_PRINCIPLE = 2'h0;
    localparam logic [7:0]        RST_DEAD_BAND     = 8'h32;
    localparam logic signed [4:0] RST_LINEARITY     = 5'sh00;
    localparam logic [10:0]       RST_MAX_FLOW      = 11'h3e8;
    localparam logic [1:0]        RST_SENS_SOURCE   = 2'h1;
    localparam logic [10:0]       RST_BASE_GRAD     = 11'h069;
    localparam logic [10:0]       RST_END_GRAD      = 11'h05a;

    localparam int DELAY_MIN   = 1;
    localparam int DELAY_MAX   = 30000;
    localparam int BRIDGE_OFF_NEVER = 30000;
    localparam int THRESH_MAX  = 100;
    localparam int DB_MAX      = 250;
    localparam int LX_MIN      = -10;
    localparam int LX_MAX      = 10;
    localparam int FULL_SCALE  = 1000;
    localparam int GRAD_MIN    = 20;
    localparam int GRAD_MAX    = 1200;
    localparam int GRAD_UNITY  = 100;
    localparam int LX_DIV      = 20000;
    localparam logic [1:0] SENS_FIXED    = 2'h1;
    localparam logic [1:0] SENS_POSITION = 2'h2;
    localparam logic [1:0] CP_OPEN_LOOP  = 2'h0;

    localparam int ST_NEUTRAL_BIT = 0;
    localparam int ST_BRIDGE_BIT  = 1;
    localparam int ST_OPEN_BIT    = 2;
    localparam int ST_FLOW_LSB    = 16;

    typedef enum logic [1:0] {
        SFSC_RUN  = 2'b00,
        SFSC_WAIT = 2'b01,
        SFSC_HOLD = 2'b11
    } sfsc_timer_t;
endpackage : sfsc_pkg
`default_nettype wire

// ===== verilog/sfsc_setpoint.sv
// Purpose: steering set-point logic with neutral and bridge timeouts
// Assumes: sensor and command words come from logic on clk
// Notes:   registers over APB, zero wait states
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module sfsc_setpoint #(
    parameter int NUM_PROG  = sfsc_pkg::NUM_PROG,
    parameter int NUM_SEL   = sfsc_pkg::NUM_SEL,
    parameter int MS_CYCLES = sfsc_pkg::MS_CYCLES
) (
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic signed [10:0] steering_input,
    input  wire logic signed [10:0] actuator_position,
    input  wire logic               position_mapped,
    input  wire logic signed [10:0] closed_loop_flow_cmd,
    output logic signed [10:0]      port_flow_request,
    output logic                    spool_neutral,
    output logic                    bridge_enable,
    output logic                    open_loop_active
);
    localparam int PW = (NUM_PROG > 1) ? $clog2(NUM_PROG) : 1;

    function automatic logic [10:0] mag11(input logic signed [10:0] v);
        logic signed [11:0] t;
        t = 12'(v);
        return (t < 0) ? 11'(-t) : 11'(t);
    endfunction : mag11

    logic [PW-1:0]       active_prog_r;
    logic [14:0]         neutral_delay_r;
    logic [6:0]          flow_thresh_r;
    logic [14:0]         bridge_delay_r;
    logic [1:0]          cp_r   [NUM_PROG];
    logic [7:0]          db_r   [NUM_PROG];
    logic signed [4:0]   lx_r   [NUM_PROG];
    logic [10:0]         qm_r   [NUM_PROG];
    logic [1:0]          sse_r  [NUM_PROG];
    logic [10:0]         g0_r   [NUM_PROG];
    logic [10:0]         g1_r   [NUM_PROG];
    logic [31:0]         prdata_r;
    logic                slverr_r;
    logic signed [10:0]  flow_r;
    logic [16:0]         div_r;
    logic                ms_tick;
    logic [14:0]         neut_cnt_r;
    logic [14:0]         br_cnt_r;

    // apb decode
    logic                setup;
    logic                wr_en;
    logic                is_prog;
    logic [11:0]         prog_off;
    logic [PW-1:0]       acc_prog;
    logic [2:0]          acc_fld;
    logic                hit;
    logic                val_ok;
    logic [31:0]         rd_val;
    int                  wv;

    assign setup  = psel && !penable;
    assign wr_en  = psel && penable && pwrite && !slverr_r;
    assign pready = 1'b1;
    assign pslverr = psel && penable && slverr_r;
    assign prdata = prdata_r;
    assign prog_off = paddr - sfsc_pkg::OFF_PROG_BASE;
    assign acc_prog = PW'(prog_off >> sfsc_pkg::PROG_STRIDE_SH);
    assign acc_fld  = prog_off[4:2];
    assign is_prog  = (paddr >= sfsc_pkg::OFF_PROG_BASE) && (paddr[1:0] == 2'h0)
                      && (int'(prog_off >> sfsc_pkg::PROG_STRIDE_SH) < NUM_PROG)
                      && (acc_fld <= sfsc_pkg::FLD_END_GRAD);
    assign wv = int'(signed'(pwdata));

    always_comb begin
        hit    = 1'b1;
        val_ok = 1'b1;
        rd_val = 32'h0000_0000;
        if (is_prog) begin
            unique case (acc_fld)
                sfsc_pkg::FLD_CTRL_PRINCIPLE: begin
                    rd_val = 32'(cp_r[acc_prog]);
                    val_ok = (wv >= 0) && (wv <= 3);
                end
                sfsc_pkg::FLD_DEAD_BAND: begin
                    rd_val = 32'(db_r[acc_prog]);
                    val_ok = (wv >= 0) && (wv <= sfsc_pkg::DB_MAX);
                end
                sfsc_pkg::FLD_LINEARITY: begin
                    rd_val = 32'(signed'(lx_r[acc_prog]));
                    val_ok = (wv >= sfsc_pkg::LX_MIN) && (wv <= sfsc_pkg::LX_MAX);
                end
                sfsc_pkg::FLD_MAX_FLOW: begin
                    rd_val = 32'(qm_r[acc_prog]);
                    val_ok = (wv >= 0) && (wv <= sfsc_pkg::FULL_SCALE);
                end
                sfsc_pkg::FLD_SENS_SOURCE: begin
                    rd_val = 32'(sse_r[acc_prog]);
                    val_ok = (pwdata[31:0] == 32'(sfsc_pkg::SENS_FIXED))
                             || (pwdata[31:0] == 32'(sfsc_pkg::SENS_POSITION));
                end
                sfsc_pkg::FLD_BASE_GRAD: begin
                    rd_val = 32'(g0_r[acc_prog]);
                    val_ok = (wv >= sfsc_pkg::GRAD_MIN) && (wv <= sfsc_pkg::GRAD_MAX);
                end
                default: begin
                    rd_val = 32'(g1_r[acc_prog]);
                    val_ok = (wv >= sfsc_pkg::GRAD_MIN) && (wv <= sfsc_pkg::GRAD_MAX);
                end
            endcase
        end else begin
            unique case (paddr)
                sfsc_pkg::OFF_ACTIVE_PROG: begin
                    rd_val = 32'(active_prog_r);
                    val_ok = (wv >= 0) && (wv < NUM_SEL);
                end
                sfsc_pkg::OFF_NEUTRAL_DELAY: begin
                    rd_val = 32'(neutral_delay_r);
                    val_ok = (wv >= sfsc_pkg::DELAY_MIN) && (wv <= sfsc_pkg::DELAY_MAX);
                end
                sfsc_pkg::OFF_FLOW_THRESH: begin
                    rd_val = 32'(flow_thresh_r);
                    val_ok = (wv >= 0) && (wv <= sfsc_pkg::THRESH_MAX);
                end
                sfsc_pkg::OFF_BRIDGE_DELAY: begin
                    rd_val = 32'(bridge_delay_r);
                    val_ok = (wv >= sfsc_pkg::DELAY_MIN) && (wv <= sfsc_pkg::DELAY_MAX);
                end
                sfsc_pkg::OFF_STATUS: begin
                    rd_val[sfsc_pkg::ST_NEUTRAL_BIT] = spool_neutral;
                    rd_val[sfsc_pkg::ST_BRIDGE_BIT]  = bridge_enable;
                    rd_val[sfsc_pkg::ST_OPEN_BIT]    = open_loop_active;
                    rd_val[31:sfsc_pkg::ST_FLOW_LSB] = 16'(port_flow_request);
                    val_ok = !pwrite;
                end
                default: hit = 1'b0;
            endcase
        end
    end

    // read data and error latched in the setup cycle, answered with no wait
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prdata_r <= 32'h0000_0000;
            slverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r <= (hit && !pwrite) ? rd_val : 32'h0000_0000;
            slverr_r <= !hit || (pwrite && !val_ok);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            active_prog_r   <= '0;
            neutral_delay_r <= sfsc_pkg::RST_NEUTRAL_DELAY;
            flow_thresh_r   <= sfsc_pkg::RST_FLOW_THRESH;
            bridge_delay_r  <= sfsc_pkg::RST_BRIDGE_DELAY;
        end else if (wr_en && !is_prog) begin
            unique case (paddr)
                sfsc_pkg::OFF_ACTIVE_PROG:   active_prog_r   <= pwdata[PW-1:0];
                sfsc_pkg::OFF_NEUTRAL_DELAY: neutral_delay_r <= pwdata[14:0];
                sfsc_pkg::OFF_FLOW_THRESH:   flow_thresh_r   <= pwdata[6:0];
                sfsc_pkg::OFF_BRIDGE_DELAY:  bridge_delay_r  <= pwdata[14:0];
                default: ;
            endcase
        end
    end

    for (genvar g = 0; g < NUM_PROG; g++) begin : g_prog
        always_ff @(posedge clk) begin
            if (!rst_b) begin
                cp_r[g]  <= sfsc_pkg::RST_CTRL_PRINCIPLE;
                db_r[g]  <= sfsc_pkg::RST_DEAD_BAND;
                lx_r[g]  <= sfsc_pkg::RST_LINEARITY;
                qm_r[g]  <= sfsc_pkg::RST_MAX_FLOW;
                sse_r[g] <= sfsc_pkg::RST_SENS_SOURCE;
                g0_r[g]  <= sfsc_pkg::RST_BASE_GRAD;
                g1_r[g]  <= sfsc_pkg::RST_END_GRAD;
            end else if (wr_en && is_prog && (int'(acc_prog) == g)) begin
                unique case (acc_fld)
                    sfsc_pkg::FLD_CTRL_PRINCIPLE: cp_r[g]  <= pwdata[1:0];
                    sfsc_pkg::FLD_DEAD_BAND:      db_r[g]  <= pwdata[7:0];
                    sfsc_pkg::FLD_LINEARITY:      lx_r[g]  <= pwdata[4:0];
                    sfsc_pkg::FLD_MAX_FLOW:       qm_r[g]  <= pwdata[10:0];
                    sfsc_pkg::FLD_SENS_SOURCE:    sse_r[g] <= pwdata[1:0];
                    sfsc_pkg::FLD_BASE_GRAD:      g0_r[g]  <= pwdata[10:0];
                    default:                      g1_r[g]  <= pwdata[10:0];
                endcase
            end
        end
    end

    // open-loop transfer chain, registered once per cycle
    int in_mag;
    int dz;
    int shaped;
    int pos_mag;
    int grad;
    int raw;
    logic signed [10:0] ol_flow;

    always_comb begin
        in_mag  = int'(mag11(steering_input));
        dz      = 0;
        shaped  = 0;
        pos_mag = 0;
        grad    = 0;
        raw     = 0;
        ol_flow = '0;
        if (in_mag > int'(db_r[active_prog_r])) begin
            dz = in_mag - int'(db_r[active_prog_r]);
        end
        if (dz > sfsc_pkg::FULL_SCALE) begin
            dz = sfsc_pkg::FULL_SCALE;
        end
        shaped = dz - (int'(lx_r[active_prog_r]) * dz * (sfsc_pkg::FULL_SCALE - dz))
                      / sfsc_pkg::LX_DIV;
        if (position_mapped) begin
            pos_mag = int'(mag11(actuator_position));
        end
        if (pos_mag > sfsc_pkg::FULL_SCALE) begin
            pos_mag = sfsc_pkg::FULL_SCALE;
        end
        grad = int'(g0_r[active_prog_r]);
        if (sse_r[active_prog_r] == sfsc_pkg::SENS_POSITION) begin
            // base at centre, end at lock
            grad = grad + ((int'(g1_r[active_prog_r]) - grad) * pos_mag)
                          / sfsc_pkg::FULL_SCALE;
        end
        raw = (shaped * grad) / sfsc_pkg::GRAD_UNITY;
        if (raw > int'(qm_r[active_prog_r])) begin
            raw = int'(qm_r[active_prog_r]);
        end
        ol_flow = (steering_input < 0) ? 11'(-raw) : 11'(raw);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flow_r <= '0;
        end else if (cp_r[active_prog_r] == sfsc_pkg::CP_OPEN_LOOP) begin
            flow_r <= ol_flow;
        end else begin
            flow_r <= closed_loop_flow_cmd;
        end
    end

    assign port_flow_request = flow_r;
    assign open_loop_active  = (cp_r[active_prog_r] == sfsc_pkg::CP_OPEN_LOOP);

    // millisecond enable; timers may run up to one ms short
    always_ff @(posedge clk) begin
        if (!rst_b || ms_tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 17'h1;
        end
    end
    assign ms_tick = (int'(div_r) == MS_CYCLES - 1);

    sfsc_pkg::sfsc_timer_t neut_st_r;
    sfsc_pkg::sfsc_timer_t br_st_r;
    logic                  cmd_settled;
    logic                  flow_zero;

    assign cmd_settled = (mag11(closed_loop_flow_cmd) <= 11'(flow_thresh_r));
    assign flow_zero   = (flow_r == '0);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            neut_st_r  <= sfsc_pkg::SFSC_RUN;
            neut_cnt_r <= '0;
        end else if (!cmd_settled) begin
            neut_st_r  <= sfsc_pkg::SFSC_RUN;
            neut_cnt_r <= '0;
        end else begin
            unique case (neut_st_r)
                sfsc_pkg::SFSC_RUN: neut_st_r <= sfsc_pkg::SFSC_WAIT;
                sfsc_pkg::SFSC_WAIT: begin
                    if (ms_tick && (neut_cnt_r + 15'h1 >= neutral_delay_r)) begin
                        neut_st_r <= sfsc_pkg::SFSC_HOLD;
                    end else if (ms_tick) begin
                        neut_cnt_r <= neut_cnt_r + 15'h1;
                    end
                end
                sfsc_pkg::SFSC_HOLD: neut_st_r <= sfsc_pkg::SFSC_HOLD;
                default: neut_st_r <= sfsc_pkg::SFSC_RUN;
            endcase
        end
    end
    assign spool_neutral = (neut_st_r == sfsc_pkg::SFSC_HOLD);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            br_st_r  <= sfsc_pkg::SFSC_RUN;
            br_cnt_r <= '0;
        end else if (!flow_zero
                     || (int'(bridge_delay_r) == sfsc_pkg::BRIDGE_OFF_NEVER)) begin
            br_st_r  <= sfsc_pkg::SFSC_RUN;
            br_cnt_r <= '0;
        end else begin
            unique case (br_st_r)
                sfsc_pkg::SFSC_RUN: br_st_r <= sfsc_pkg::SFSC_WAIT;
                sfsc_pkg::SFSC_WAIT: begin
                    if (ms_tick && (br_cnt_r + 15'h1 >= bridge_delay_r)) begin
                        br_st_r <= sfsc_pkg::SFSC_HOLD;
                    end else if (ms_tick) begin
                        br_cnt_r <= br_cnt_r + 15'h1;
                    end
                end
                sfsc_pkg::SFSC_HOLD: br_st_r <= sfsc_pkg::SFSC_HOLD;
                default: br_st_r <= sfsc_pkg::SFSC_RUN;
            endcase
        end
    end
    assign bridge_enable = (br_st_r != sfsc_pkg::SFSC_HOLD) || !flow_zero;
endmodule : sfsc_setpoint
`default_nettype wire
